/* File: cvd_pkg.sv */
/*
  cvd_pkg: register offsets, field positions, reset values and codes for the
  common converter control block.
  assumes: APB slave with 32-bit data, one register per aligned word.
*/
package cvd_pkg;
  localparam logic [11:0] ADDR_CTRL_ONE = 12'h000;
  localparam logic [11:0] ADDR_CTRL_TWO = 12'h004;
  localparam logic [11:0] ADDR_DONE_STATUS = 12'h008;
  localparam logic [7:0] RESET_CTRL_ONE = 8'h00;
  localparam logic [7:0] RESET_CTRL_TWO = 8'h00;
  localparam logic [7:0] MASK_CTRL_ONE = 8'hF3;
  localparam logic [7:0] MASK_CTRL_TWO = 8'h70;
  localparam int JUSTIFY_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int START_BIT = 2;
  localparam int PREF_LSB = 0;
  localparam int TRIG_LSB = 4;
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_RESERVED = 2'h1;
  localparam logic [1:0] PREF_EXT_PIN = 2'h2;
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_TIMER0_OVF = 3'h3;
  localparam logic [2:0] TRIG_TIMER1_OVF = 3'h4;
  localparam logic [2:0] TRIG_TIMER2_MATCH = 3'h5;
  localparam logic [2:0] TRIG_EXT_RISE = 3'h6;
  localparam logic [2:0] TRIG_EXT_FALL = 3'h7;
  localparam logic [2:0] CLKSEL_RC = 3'h7;
endpackage : cvd_pkg

/* File: cvd_common_ctrl.sv */
/*
  cvd_common_ctrl: common control of a set of converters: clock, reference
  and justification selects, synchronised start with combined done, and
  automatic trigger selection.
  assumes: one clock, async active-high reset, inputs synchronous to clock,
  timer inputs are the one-cycle pulses that set the timers' interrupt flags.
*/
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cvd_common_ctrl #(
  parameter int NUM_ADC = 2
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [NUM_ADC-1:0] ADC_ENABLE_IN,
  input wire logic [NUM_ADC-1:0] PER_CONVERTER_DONE_FLAG_IN,
  input wire logic TIMER0_OVF_FLAG_SET_IN,
  input wire logic TIMER1_OVF_FLAG_SET_IN,
  input wire logic TIMER2_MATCH_FLAG_SET_IN,
  input wire logic EXTERNAL_TRIGGER_INPUT_IN,
  output logic [NUM_ADC-1:0] ADC_START_OUT,
  output logic RESULT_JUSTIFY_SELECT_OUT,
  output logic [2:0] CONVERSION_CLOCK_SELECT_OUT,
  output logic DEDICATED_RC_CLOCK_SEL_OUT,
  output logic [1:0] POSITIVE_REFERENCE_SELECT_OUT,
  output logic [2:0] AUTO_TRIGGER_SELECT_OUT
);
  typedef enum logic [1:0] {
    CVD_IDLE_S = 2'b01,
    CVD_ACCESS_S = 2'b10
  } cvd_bus_t;

  logic [7:0] ctrl_one;
  logic [7:0] next_ctrl_one;
  logic [7:0] ctrl_two;
  logic [7:0] next_ctrl_two;
  logic ext_prev;
  logic [NUM_ADC-1:0] start;
  logic [NUM_ADC-1:0] next_start;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  cvd_bus_t bus_state;
  cvd_bus_t next_bus_state;
  logic wr_one;
  logic wr_two;
  logic rd_setup;
  logic sw_start;
  logic auto_trig;
  logic any_done;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_one = PSEL_IN && PENABLE_IN && PWRITE_IN && hit(PADDR_IN, cvd_pkg::ADDR_CTRL_ONE);
  assign sw_start = wr_one && PWDATA_IN[cvd_pkg::START_BIT];
  assign any_done = |PER_CONVERTER_DONE_FLAG_IN;
  assign wr_two = PSEL_IN && PENABLE_IN && PWRITE_IN && hit(PADDR_IN, cvd_pkg::ADDR_CTRL_TWO);
  // read data is captured only in a setup cycle, which always meets the idle state
  assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN && (bus_state == CVD_IDLE_S);

  // trigger select decode
  always_comb begin
    case (ctrl_two[cvd_pkg::TRIG_LSB +: 3])
      cvd_pkg::TRIG_TIMER0_OVF: auto_trig = TIMER0_OVF_FLAG_SET_IN;
      cvd_pkg::TRIG_TIMER1_OVF: auto_trig = TIMER1_OVF_FLAG_SET_IN;
      cvd_pkg::TRIG_TIMER2_MATCH: auto_trig = TIMER2_MATCH_FLAG_SET_IN;
      cvd_pkg::TRIG_EXT_RISE: auto_trig = EXTERNAL_TRIGGER_INPUT_IN && !ext_prev;
      cvd_pkg::TRIG_EXT_FALL: auto_trig = !EXTERNAL_TRIGGER_INPUT_IN && ext_prev;
      default: auto_trig = 1'b0;
    endcase
  end

  // register writes, start pulses and read data
  always_comb begin
    next_ctrl_one = ctrl_one;
    next_ctrl_two = ctrl_two;
    next_rdata = rdata;
    next_bus_state = bus_state;
    next_start = ADC_ENABLE_IN & {NUM_ADC{sw_start || auto_trig}};
    case (bus_state)
      CVD_IDLE_S: begin
        if (PSEL_IN) begin
          next_bus_state = CVD_ACCESS_S;
        end
      end
      CVD_ACCESS_S: begin
        next_bus_state = CVD_IDLE_S;
      end
      default: next_bus_state = CVD_IDLE_S;
    endcase
    if (wr_one) begin
      next_ctrl_one = PWDATA_IN[7:0] & cvd_pkg::MASK_CTRL_ONE & ~8'h04;
    end
    if (wr_two) begin
      next_ctrl_two = PWDATA_IN[7:0] & cvd_pkg::MASK_CTRL_TWO;
    end
    if (rd_setup) begin
      if (hit(PADDR_IN, cvd_pkg::ADDR_CTRL_ONE)) begin
        next_rdata = {24'h000000, ctrl_one[7:3], any_done, ctrl_one[1:0]};
      end else if (hit(PADDR_IN, cvd_pkg::ADDR_CTRL_TWO)) begin
        next_rdata = {24'h000000, ctrl_two};
      end else if (hit(PADDR_IN, cvd_pkg::ADDR_DONE_STATUS)) begin
        next_rdata = 32'(PER_CONVERTER_DONE_FLAG_IN);
      end else begin
        next_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_one <= cvd_pkg::RESET_CTRL_ONE;
      ctrl_two <= cvd_pkg::RESET_CTRL_TWO;
      ext_prev <= 1'b0;
      start <= '0;
      rdata <= 32'h00000000;
      bus_state <= CVD_IDLE_S;
    end else begin
      ctrl_one <= next_ctrl_one;
      ctrl_two <= next_ctrl_two;
      ext_prev <= EXTERNAL_TRIGGER_INPUT_IN;
      start <= next_start;
      rdata <= next_rdata;
      bus_state <= next_bus_state;
    end
  end

  assign PRDATA_OUT = rdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit(PADDR_IN, cvd_pkg::ADDR_CTRL_ONE)
    && !hit(PADDR_IN, cvd_pkg::ADDR_CTRL_TWO) && !hit(PADDR_IN, cvd_pkg::ADDR_DONE_STATUS);
  assign ADC_START_OUT = start;
  assign RESULT_JUSTIFY_SELECT_OUT = ctrl_one[cvd_pkg::JUSTIFY_BIT];
  assign CONVERSION_CLOCK_SELECT_OUT = ctrl_one[cvd_pkg::CLKSEL_LSB +: 3];
  assign DEDICATED_RC_CLOCK_SEL_OUT = (ctrl_one[cvd_pkg::CLKSEL_LSB +: 3] == cvd_pkg::CLKSEL_RC);
  assign POSITIVE_REFERENCE_SELECT_OUT = ctrl_one[cvd_pkg::PREF_LSB +: 2];
  assign AUTO_TRIGGER_SELECT_OUT = ctrl_two[cvd_pkg::TRIG_LSB +: 3];

  // checks
  sw_start_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    sw_start |=> (ADC_START_OUT == $past(ADC_ENABLE_IN)))
    else $error("software start missed an enabled converter");
  ref_field_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    wr_one |=> (POSITIVE_REFERENCE_SELECT_OUT == $past(PWDATA_IN[1:0])))
    else $error("reference select not stored");
  trig_idle_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_NONE && !sw_start) |=> ADC_START_OUT == '0)
    else $error("start with no trigger selected");
  rise_trig_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_EXT_RISE && $rose(EXTERNAL_TRIGGER_INPUT_IN))
    |=> ADC_START_OUT == $past(ADC_ENABLE_IN))
    else $error("rising edge trigger missed");
  fall_trig_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_EXT_FALL && $fell(EXTERNAL_TRIGGER_INPUT_IN))
    |=> ADC_START_OUT == $past(ADC_ENABLE_IN))
    else $error("falling edge trigger missed");
  timer_trig_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_TIMER1_OVF && TIMER1_OVF_FLAG_SET_IN)
    |=> ADC_START_OUT == $past(ADC_ENABLE_IN))
    else $error("timer one trigger missed");
  unimpl_zero_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ((ctrl_one & ~cvd_pkg::MASK_CTRL_ONE) == 8'h00) && ((ctrl_two & ~cvd_pkg::MASK_CTRL_TWO) == 8'h00))
    else $error("unimplemented bit set");
  rc_sel_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    wr_one |=> (CONVERSION_CLOCK_SELECT_OUT == $past(PWDATA_IN[6:4]))
    && (DEDICATED_RC_CLOCK_SEL_OUT == ($past(PWDATA_IN[6:4]) == cvd_pkg::CLKSEL_RC)))
    else $error("clock select not stored");
  timer_zero_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_TIMER0_OVF && TIMER0_OVF_FLAG_SET_IN)
    |=> ADC_START_OUT == $past(ADC_ENABLE_IN))
    else $error("timer zero trigger missed");
  timer_match_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_TIMER2_MATCH && TIMER2_MATCH_FLAG_SET_IN)
    |=> ADC_START_OUT == $past(ADC_ENABLE_IN))
    else $error("timer two trigger missed");
  reserved_trig_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ((AUTO_TRIGGER_SELECT_OUT == 3'h1 || AUTO_TRIGGER_SELECT_OUT == 3'h2) && !sw_start)
    |=> ADC_START_OUT == '0)
    else $error("start from a reserved trigger code");
  trig_store_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    wr_two |=> AUTO_TRIGGER_SELECT_OUT == $past(PWDATA_IN[6:4]))
    else $error("trigger select not stored");
  rise_quiet_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_EXT_RISE && !$rose(EXTERNAL_TRIGGER_INPUT_IN)
    && !sw_start) |=> ADC_START_OUT == '0)
    else $error("start without a rising edge");
  fall_quiet_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_EXT_FALL && !$fell(EXTERNAL_TRIGGER_INPUT_IN)
    && !sw_start) |=> ADC_START_OUT == '0)
    else $error("start without a falling edge");
  enable_gate_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (ADC_START_OUT & ~$past(ADC_ENABLE_IN)) == '0)
    else $error("start given to a disabled converter");
  done_read_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (rd_setup && hit(PADDR_IN, cvd_pkg::ADDR_CTRL_ONE))
    |=> PRDATA_OUT[cvd_pkg::START_BIT] == ($past(PER_CONVERTER_DONE_FLAG_IN) != '0))
    else $error("start bit does not read as the done flags");
  read_one_zero_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (rd_setup && hit(PADDR_IN, cvd_pkg::ADDR_CTRL_ONE)) |=> (PRDATA_OUT
    & ~(32'(cvd_pkg::MASK_CTRL_ONE) | (32'h00000001 << cvd_pkg::START_BIT))) == 32'h00000000)
    else $error("control one reads a set unimplemented bit");
  read_two_zero_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (rd_setup && hit(PADDR_IN, cvd_pkg::ADDR_CTRL_TWO))
    |=> (PRDATA_OUT & ~32'(cvd_pkg::MASK_CTRL_TWO)) == 32'h00000000)
    else $error("control two reads a set unimplemented bit");
  read_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN) PSEL_IN && !PWRITE_IN && PENABLE_IN);
  sw_start_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN) sw_start);
  ext_trig_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN) auto_trig && ext_prev);
  timer_trig_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
    auto_trig && AUTO_TRIGGER_SELECT_OUT == cvd_pkg::TRIG_TIMER2_MATCH);
  rise_trig_c: cover property (@(posedge CLK_IN) disable iff (RESET_IN)
    auto_trig && EXTERNAL_TRIGGER_INPUT_IN && !ext_prev);
endmodule : cvd_common_ctrl

/* File: testbench.sv */
/*
  testbench: drives the common converter control over apb and its trigger pins.
  assumes: cvd_pkg offsets, zero-wait apb slave, start pulse within two cycles.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, perr, errs, just, rcs;
  logic [1:0] en = 2'h0, done = 2'h0, start, pref;
  logic [3:0] stim = 4'h0;
  logic [2:0] cks, trg;
  int err_count = 0, n_compared = 0, n;
  always #5 clk = ~clk;
  cvd_common_ctrl u_dut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .ADC_ENABLE_IN(en), .PER_CONVERTER_DONE_FLAG_IN(done),
    .TIMER0_OVF_FLAG_SET_IN(stim[0]), .TIMER1_OVF_FLAG_SET_IN(stim[1]),
    .TIMER2_MATCH_FLAG_SET_IN(stim[2]), .EXTERNAL_TRIGGER_INPUT_IN(stim[3]),
    .ADC_START_OUT(start), .RESULT_JUSTIFY_SELECT_OUT(just), .CONVERSION_CLOCK_SELECT_OUT(cks),
    .DEDICATED_RC_CLOCK_SEL_OUT(rcs), .POSITIVE_REFERENCE_SELECT_OUT(pref),
    .AUTO_TRIGGER_SELECT_OUT(trg));
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      complete_run();
    end
    rd = prd;
    errs = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task count_starts(output int c);
    c = 0;
    repeat (3) begin
      #1;
      if (start !== 2'h0) begin
        c++;
        chk(32'(start), 32'(en));
      end
      @(posedge clk);
    end
  endtask : count_starts
  task fire(input logic [3:0] v, input int exp);
    @(posedge clk);
    stim <= v;
    @(posedge clk);
    stim[2:0] <= 3'h0;
    count_starts(n);
    chk(n, exp);
  endtask : fire
  task t_reset;
    apb(1'b0, cvd_pkg::ADDR_CTRL_ONE, 32'h0);
    chk(rd, 32'h0);
    chk(32'(errs), 32'h0);
    apb(1'b0, cvd_pkg::ADDR_CTRL_TWO, 32'h0);
    chk(rd, 32'h0);
    chk(32'({just, cks, rcs, pref, trg}), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task t_fields;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, cvd_pkg::ADDR_CTRL_ONE, {24'h0, 1'b1, 3'(i + 5), 1'b1, 1'b0, 2'(i)});
      apb(1'b0, cvd_pkg::ADDR_CTRL_ONE, 32'h0);
      chk(rd, {24'h0, 1'b1, 3'(i + 5), 2'h0, 2'(i)});
      chk(32'({just, cks, rcs, pref}), 32'({1'b1, 3'(i + 5), i == 2, 2'(i)}));
    end
    apb(1'b1, cvd_pkg::ADDR_CTRL_TWO, 32'hFF);
    apb(1'b0, cvd_pkg::ADDR_CTRL_TWO, 32'h0);
    chk(rd, 32'h70);
    chk(32'(trg), 32'h7);
    apb(1'b1, cvd_pkg::ADDR_CTRL_TWO, 32'h8F);
    apb(1'b0, cvd_pkg::ADDR_CTRL_TWO, 32'h0);
    chk(rd, 32'h0);
    $display("test fields done");
  endtask : t_fields
  task t_start;
    en <= 2'h1;
    done <= 2'h2;
    apb(1'b1, cvd_pkg::ADDR_CTRL_ONE, 32'h04);
    count_starts(n);
    chk(n, 1);
    apb(1'b0, cvd_pkg::ADDR_CTRL_ONE, 32'h0);
    chk(rd, 32'h04);
    apb(1'b0, cvd_pkg::ADDR_DONE_STATUS, 32'h0);
    chk(rd, 32'h2);
    en <= 2'h3;
    done <= 2'h0;
    apb(1'b1, cvd_pkg::ADDR_CTRL_ONE, 32'h04);
    count_starts(n);
    chk(n, 1);
    apb(1'b0, cvd_pkg::ADDR_CTRL_ONE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(errs), 32'h1);
    chk(rd, 32'h0);
    $display("test start done");
  endtask : t_start
  task t_triggers;
    en <= 2'h1;
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, cvd_pkg::ADDR_CTRL_TWO, 32'(c << 4));
      for (int t = 0; t < 3; t++) fire(4'(1 << t), int'(c == t + 3));
    end
    apb(1'b1, cvd_pkg::ADDR_CTRL_TWO, 32'h60);
    fire(4'h8, 1);
    fire(4'h0, 0);
    apb(1'b1, cvd_pkg::ADDR_CTRL_TWO, 32'h70);
    fire(4'h8, 0);
    fire(4'h0, 1);
    $display("test triggers done");
  endtask : t_triggers
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_start();
    t_triggers();
    complete_run();
  end
endmodule : testbench
